/* rtl/cmec_counter.sv */
// compare-match event counter with compare list, input filter and wishbone registers
// assumes a classic wishbone master on sys_clk_in; cnt_src_in is asynchronous
// Function
// - count advances on the external input while running
// - an external clock is accepted as the counted signal
// - a count equal to compare value is a match and triggers the match action
// - with loading enabled, each match loads the next list entry as compare value
// - after the last entry, wrap to the first or hold the last, as configured
// - input filter selectable: bypassed or 1 us stability time
// - every match raises a match event
// - every overrun raises an overrun event
// - an operation error that stops counting raises an error event
// - counting starts only on a software command and stops on stop or error; stop works anytime while running
// - status and count readable while running without disturbing counting
// - running flag set by start, held until stop, counter reset or error
// - match flag set by any match after start, cleared only by status reset or counter reset
// - overrun flag set by a match while match flag set; cleared by status reset
// - overrun does not halt counting
// - matches arriving too fast set operation error and stop counting
// - present count value returned on software read
// - counter reset returns the counter to its power-on state, except bus answer and input synchroniser
// - status reset clears match and overrun flags
module cmec_counter
	import cmec_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// register bus
	input wire cmec_wb_req_t wb_req_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// counted signal
	input wire logic cnt_src_in,
	// event pulses
	output logic ev_match_out,
	output logic ev_overrun_out,
	output logic ev_error_out
);

	// ---------------------------------------------------------------
	// state and decode
	// ---------------------------------------------------------------
	cmec_st_t st_reg;
	cmec_st_t st_next;
	cmec_st_t st_clr;
	logic bus_req;
	logic wr_ctrl;
	logic running;
	logic cnt_edge;
	logic [31:0] cnt_inc;
	logic match_hit;
	logic cmd_start;
	logic cmd_stop;
	logic cmd_cnt_rst;
	logic cmd_stat_rst;
	logic [CMEC_IDX_W-1:0] load_idx;

	// byte-lane merge of write data, used for every wide register
	function automatic logic [31:0] cmec_merge(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] sel);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction : cmec_merge

	// one request per ack; masking the request while ack is high blocks a double take
	assign bus_req = wb_req_in.cyc & wb_req_in.stb & ~st_reg.ack;
	assign wr_ctrl = bus_req & wb_req_in.we & wb_req_in.sel[0]
		& (wb_req_in.adr == CMEC_OFS_CTRL);
	assign cmd_start = wr_ctrl & wb_req_in.dat[CMEC_CTRL_START];
	assign cmd_stop = wr_ctrl & wb_req_in.dat[CMEC_CTRL_STOP];
	assign cmd_cnt_rst = wr_ctrl & wb_req_in.dat[CMEC_CTRL_CNT_RST];
	assign cmd_stat_rst = wr_ctrl & wb_req_in.dat[CMEC_CTRL_STAT_RST];

	assign cnt_edge = st_reg.filt_lvl & ~st_reg.filt_prev;
	assign running = (st_reg.state == CMEC_RUN);
	assign cnt_inc = st_reg.count + 32'h0000_0001;
	assign match_hit = running & cnt_edge & (cnt_inc == st_reg.cmp);

	// next list entry: wrap to first, or hold the last one
	always_comb begin
		if (st_reg.idx != st_reg.list_last) begin
			load_idx = st_reg.idx + CMEC_IDX_W'(1);
		end else if (st_reg.wrap_en) begin
			load_idx = '0;
		end else begin
			load_idx = st_reg.idx;
		end
	end

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.ev_match = 1'b0;
		st_next.ev_ovr = 1'b0;
		st_next.ev_err = 1'b0;

		// pin passes two flops before the filter reads it
		st_next.sync1 = cnt_src_in;
		st_next.sync2 = st_reg.sync1;

		// filter needs a new level stable for the whole filter time
		st_next.filt_prev = st_reg.filt_lvl;
		if (!st_reg.filt_en) begin
			st_next.filt_lvl = st_reg.sync2;
			st_next.filt_cnt = '0;
		end else if (st_reg.sync2 == st_reg.filt_lvl) begin
			st_next.filt_cnt = '0;
		end else if (st_reg.filt_cnt == CMEC_FILT_LAST) begin
			st_next.filt_lvl = st_reg.sync2;
			st_next.filt_cnt = '0;
		end else begin
			st_next.filt_cnt = st_reg.filt_cnt + CMEC_FILT_W'(1);
		end

		// bus answer: ack one cycle after the request, read data registered
		st_next.ack = bus_req;
		if (bus_req && !wb_req_in.we) begin
			unique case (wb_req_in.adr)
				CMEC_OFS_CONFIG: st_next.rdata = {29'h0, st_reg.wrap_en,
					st_reg.load_en, st_reg.filt_en};
				// status read has no side effect
				CMEC_OFS_STATUS: st_next.rdata = {28'h0, st_reg.err_flg,
					st_reg.ovr_flg, st_reg.match_flg, running};
				CMEC_OFS_COUNT: st_next.rdata = st_reg.count;
				CMEC_OFS_COMPARE: st_next.rdata = st_reg.cmp;
				CMEC_OFS_LIST_LAST: st_next.rdata = 32'(st_reg.list_last);
				CMEC_OFS_LIST_PTR: st_next.rdata = 32'(st_reg.list_ptr);
				CMEC_OFS_LIST_DATA: st_next.rdata = st_reg.list[st_reg.list_ptr];
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end

		// register writes
		if (bus_req && wb_req_in.we) begin
			unique case (wb_req_in.adr)
				CMEC_OFS_CONFIG: begin
					if (wb_req_in.sel[0]) begin
						st_next.filt_en = wb_req_in.dat[CMEC_CFG_FILT_EN];
						st_next.load_en = wb_req_in.dat[CMEC_CFG_LOAD_EN];
						st_next.wrap_en = wb_req_in.dat[CMEC_CFG_WRAP_EN];
					end
				end
				CMEC_OFS_COMPARE: st_next.cmp = cmec_merge(st_reg.cmp,
					wb_req_in.dat, wb_req_in.sel);
				CMEC_OFS_LIST_LAST: begin
					if (wb_req_in.sel[0]) begin
						st_next.list_last = wb_req_in.dat[CMEC_IDX_W-1:0];
					end
				end
				CMEC_OFS_LIST_PTR: begin
					if (wb_req_in.sel[0]) begin
						st_next.list_ptr = wb_req_in.dat[CMEC_IDX_W-1:0];
					end
				end
				// list entries are written in sequence, pointer steps after each
				CMEC_OFS_LIST_DATA: begin
					st_next.list[st_reg.list_ptr] = cmec_merge(
						st_reg.list[st_reg.list_ptr], wb_req_in.dat, wb_req_in.sel);
					st_next.list_ptr = st_reg.list_ptr + CMEC_IDX_W'(1);
				end
				default: begin
				end
			endcase
		end

		// start and stop commands; stop wins when both are written
		if (cmd_stop && running) begin
			st_next.state = CMEC_IDLE;
		end else if (cmd_start && !cmd_stop && st_reg.state == CMEC_IDLE) begin
			st_next.state = CMEC_RUN;
			if (st_reg.load_en) begin
				st_next.idx = '0;
				st_next.cmp = st_reg.list[0];
			end
		end

		// status reset, placed before events so that a set wins
		if (cmd_stat_rst) begin
			st_next.match_flg = 1'b0;
			st_next.ovr_flg = 1'b0;
		end

		// count while running, using the state before this cycle's commands
		if (running && cnt_edge) begin
			st_next.count = cnt_inc;
		end

		if (match_hit) begin
			st_next.match_flg = 1'b1;
			st_next.ev_match = 1'b1;
			// overrun alone leaves the state untouched, counting goes on
			// overrun on a match with match flag still set
			if (st_reg.match_flg) begin
				st_next.ovr_flg = 1'b1;
				st_next.ev_ovr = 1'b1;
			end
			// a match on top of an overrun is served too late: halt
			if (st_reg.ovr_flg) begin
				st_next.err_flg = 1'b1;
				st_next.ev_err = 1'b1;
				st_next.state = CMEC_HALT;
			end
			// next compare value in the same cycle
			if (st_reg.load_en) begin
				st_next.idx = load_idx;
				st_next.cmp = st_reg.list[load_idx];
			end
		end

		// counter reset: everything back to power-on values but the bus answer and the synchroniser flops
		st_clr = CMEC_ST_RST;
		st_clr.ack = st_next.ack;
		st_clr.rdata = st_next.rdata;
		st_clr.sync1 = st_next.sync1;
		st_clr.sync2 = st_next.sync2;
		if (cmd_cnt_rst) begin
			st_next = st_clr;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_reg <= CMEC_ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flops
	assign wb_dat_out = st_reg.rdata;
	assign wb_ack_out = st_reg.ack;
	assign ev_match_out = st_reg.ev_match;
	assign ev_overrun_out = st_reg.ev_ovr;
	assign ev_error_out = st_reg.ev_err;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);

	logic rd_count;
	assign rd_count = bus_req & ~wb_req_in.we & (wb_req_in.adr == CMEC_OFS_COUNT);
	logic rd_status;
	assign rd_status = bus_req & ~wb_req_in.we & (wb_req_in.adr == CMEC_OFS_STATUS);

	AST_COUNT_STEP: assert property (running && cnt_edge && !cmd_cnt_rst
		|=> st_reg.count == $past(st_reg.count) + 32'h0000_0001)
		else $error("count did not advance on an edge while running");
	AST_IDLE_HOLD: assert property (!running && !cmd_cnt_rst
		|=> $stable(st_reg.count))
		else $error("count changed while not running");
	AST_START_RUN: assert property (cmd_start && !cmd_stop && !cmd_cnt_rst
		&& st_reg.state == CMEC_IDLE |=> running)
		else $error("start did not set the running flag");
	AST_STOP_IDLE: assert property (cmd_stop && running
		|=> st_reg.state == CMEC_IDLE)
		else $error("stop command not honoured");
	AST_MATCH_EV: assert property (match_hit && !cmd_cnt_rst
		|=> ev_match_out && st_reg.match_flg ##1 !ev_match_out)
		else $error("match did not give one event pulse and the flag");
	AST_LOAD_NEXT: assert property (match_hit && st_reg.load_en && !cmd_cnt_rst
		|=> st_reg.cmp == $past(st_reg.list[load_idx]) && st_reg.idx == $past(load_idx))
		else $error("next compare value not loaded with the match");
	AST_HOLD_LAST: assert property (match_hit && st_reg.load_en && !st_reg.wrap_en
		&& st_reg.idx == st_reg.list_last && !cmd_cnt_rst |=> $stable(st_reg.idx))
		else $error("list index moved past the last entry without wrap");
	AST_OVERRUN: assert property (match_hit && st_reg.match_flg && !cmd_cnt_rst
		|=> st_reg.ovr_flg && ev_overrun_out)
		else $error("overrun not flagged on a repeated match");
	AST_OVR_RUNS: assert property (match_hit && st_reg.match_flg && !st_reg.ovr_flg
		&& !cmd_stop && !cmd_cnt_rst |=> running)
		else $error("overrun stopped the counter");
	AST_OP_ERROR: assert property (match_hit && st_reg.ovr_flg && !cmd_cnt_rst
		|=> !running && st_reg.err_flg && ev_error_out)
		else $error("operation error did not halt the counter");
	AST_STAT_CLR: assert property (cmd_stat_rst && !match_hit
		|=> !st_reg.match_flg && !st_reg.ovr_flg)
		else $error("status reset left a flag set");
	AST_CNT_RST: assert property (cmd_cnt_rst
		|=> st_reg.state == CMEC_IDLE && st_reg.count == CMEC_COUNT_RST
		&& !st_reg.err_flg && !st_reg.match_flg && !st_reg.load_en)
		else $error("counter reset did not restore the power-on state");
	AST_COUNT_READ: assert property (rd_count
		|=> wb_ack_out && wb_dat_out == $past(st_reg.count) ##1 !wb_ack_out)
		else $error("count read returned a wrong value or ack");
	// filtered level moves only after the full filter time
	AST_FILTER: assert property (st_reg.filt_en && $past(st_reg.filt_en)
		&& $changed(st_reg.filt_lvl) |-> $past(st_reg.filt_cnt) == CMEC_FILT_LAST)
		else $error("filtered level changed before the filter time");
	// bypassed filter follows the synchroniser by one cycle
	AST_FILT_BYPASS: assert property (!st_reg.filt_en && !cmd_cnt_rst
		|=> st_reg.filt_lvl == $past(st_reg.sync2))
		else $error("bypassed filter did not follow the input");
	// status read shows every flag in its own field
	AST_STAT_READ: assert property (rd_status
		|=> wb_dat_out[CMEC_STAT_RUN] == $past(running)
		&& wb_dat_out[CMEC_STAT_MATCH] == $past(st_reg.match_flg)
		&& wb_dat_out[CMEC_STAT_OVR] == $past(st_reg.ovr_flg)
		&& wb_dat_out[CMEC_STAT_ERR] == $past(st_reg.err_flg) && wb_dat_out[31:4] == 28'h0)
		else $error("status read returned wrong flags");
	// every request gets a single ack pulse
	AST_BUS_ACK: assert property (bus_req |=> wb_ack_out ##1 !wb_ack_out)
		else $error("bus request not answered by a one-cycle ack");
	// a match event only follows a count equal to the compare value
	AST_MATCH_VAL: assert property (ev_match_out
		|-> st_reg.count == $past(st_reg.cmp))
		else $error("match event without an equal count");
	AST_NO_IDLE_EV: assert property (!running |=> !ev_match_out)
		else $error("match event while the counter was stopped");
	// only a start command leaves idle
	AST_IDLE_STAY: assert property (st_reg.state == CMEC_IDLE && !cmd_start
		|=> !running)
		else $error("counter began running without a start command");
	// running holds until stop, counter reset or error
	AST_RUN_HOLD: assert property (running && !cmd_stop && !cmd_cnt_rst
		&& !(match_hit && st_reg.ovr_flg) |=> running)
		else $error("running flag dropped without stop or error");
	// match flag cleared only by a reset command
	AST_MATCH_KEEP: assert property (st_reg.match_flg && !cmd_stat_rst && !cmd_cnt_rst
		|=> st_reg.match_flg)
		else $error("match flag cleared without status reset");
	// overrun flag cleared only by a reset command
	AST_OVR_KEEP: assert property (st_reg.ovr_flg && !cmd_stat_rst && !cmd_cnt_rst
		|=> st_reg.ovr_flg)
		else $error("overrun flag cleared without status reset");
	// error halt lasts until counter reset
	AST_ERR_STICKY: assert property (st_reg.err_flg && !cmd_cnt_rst
		|=> st_reg.err_flg && st_reg.state == CMEC_HALT)
		else $error("operation error state left without counter reset");

	// ---------------------------------------------------------------
	// cover properties
	// ---------------------------------------------------------------
	COV_WRAP: cover property (match_hit && st_reg.load_en && st_reg.wrap_en
		&& st_reg.idx == st_reg.list_last);
	COV_OVERRUN: cover property (ev_overrun_out);
	COV_ERROR: cover property (ev_error_out);
	COV_FILT_EDGE: cover property (st_reg.filt_en && cnt_edge && running);
	COV_HOLD_LAST: cover property (match_hit && st_reg.load_en && !st_reg.wrap_en
		&& st_reg.idx == st_reg.list_last);

endmodule : cmec_counter

/* include/cmec_pkg.sv */
// package of the compare-match event counter: register map, fields, timing, types
// assumes a 40 MHz board clock and a 32-bit classic wishbone register bus
package cmec_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] CMEC_OFS_CTRL = 8'h00;
	localparam logic [7:0] CMEC_OFS_CONFIG = 8'h04;
	localparam logic [7:0] CMEC_OFS_STATUS = 8'h08;
	localparam logic [7:0] CMEC_OFS_COUNT = 8'h0c;
	localparam logic [7:0] CMEC_OFS_COMPARE = 8'h10;
	localparam logic [7:0] CMEC_OFS_LIST_LAST = 8'h14;
	localparam logic [7:0] CMEC_OFS_LIST_PTR = 8'h18;
	localparam logic [7:0] CMEC_OFS_LIST_DATA = 8'h1c;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CMEC_CTRL_START = 0;
	localparam int CMEC_CTRL_STOP = 1;
	localparam int CMEC_CTRL_CNT_RST = 2;
	localparam int CMEC_CTRL_STAT_RST = 3;
	localparam int CMEC_CFG_FILT_EN = 0;
	localparam int CMEC_CFG_LOAD_EN = 1;
	localparam int CMEC_CFG_WRAP_EN = 2;
	localparam int CMEC_STAT_RUN = 0;
	localparam int CMEC_STAT_MATCH = 1;
	localparam int CMEC_STAT_OVR = 2;
	localparam int CMEC_STAT_ERR = 3;

	// ---------------------------------------------------------------
	// sizes and timing
	// ---------------------------------------------------------------
	localparam int CMEC_LIST_DEPTH = 8;
	localparam int CMEC_IDX_W = $clog2(CMEC_LIST_DEPTH);
	localparam int CMEC_CLK_PERIOD_PS = 25000;
	localparam int CMEC_FILT_TIME_US = 1;
	localparam int CMEC_FILT_TIME_PS = CMEC_FILT_TIME_US * 1000000;
	// least time: round up to whole cycles
	localparam int CMEC_FILT_CYC = (CMEC_FILT_TIME_PS + CMEC_CLK_PERIOD_PS - 1) / CMEC_CLK_PERIOD_PS;
	localparam int CMEC_FILT_W = $clog2(CMEC_FILT_CYC + 1);
	localparam logic [CMEC_FILT_W-1:0] CMEC_FILT_LAST = CMEC_FILT_W'(CMEC_FILT_CYC - 1);
	localparam logic [31:0] CMEC_COUNT_RST = 32'h0000_0000;
	localparam logic [31:0] CMEC_COMPARE_RST = 32'h0000_0000;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CMEC_IDLE = 3'b001,
		CMEC_RUN = 3'b010,
		CMEC_HALT = 3'b100
	} cmec_state_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} cmec_wb_req_t;

	typedef struct packed {
		cmec_state_t state;
		logic [31:0] count;
		logic [31:0] cmp;
		logic [CMEC_LIST_DEPTH-1:0][31:0] list;
		logic [CMEC_IDX_W-1:0] idx;
		logic [CMEC_IDX_W-1:0] list_last;
		logic [CMEC_IDX_W-1:0] list_ptr;
		logic filt_en;
		logic load_en;
		logic wrap_en;
		logic match_flg;
		logic ovr_flg;
		logic err_flg;
		logic sync1;
		logic sync2;
		logic filt_lvl;
		logic filt_prev;
		logic [CMEC_FILT_W-1:0] filt_cnt;
		logic ack;
		logic [31:0] rdata;
		logic ev_match;
		logic ev_ovr;
		logic ev_err;
	} cmec_st_t;

	localparam cmec_st_t CMEC_ST_RST = '{state: CMEC_IDLE, count: CMEC_COUNT_RST,
		cmp: CMEC_COMPARE_RST, default: '0};

endpackage : cmec_pkg

/* tb/cmec_pulse_src.sv */
// model of the external pulse or clock source on the counted input
// assumes a one-cycle go strobe, set right after a rising edge of sys_clk_in
module cmec_pulse_src (
	// clock
	input wire logic sys_clk_in,
	// burst request
	input wire logic go_in,
	input wire logic [7:0] npulse_in,
	input wire logic [7:0] half_in,
	// counted signal
	output logic src_out,
	output logic busy_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// external clock burst
	// the line stands low between bursts, as a gated clock source would
	initial begin
		src_out = 1'b0;
		busy_out = 1'b0;
		forever begin
			@(posedge sys_clk_in);
			if (go_in === 1'b1) begin
				busy_out <= 1'b1;
				repeat (npulse_in) begin
					src_out <= 1'b1;
					repeat (half_in) @(posedge sys_clk_in);
					src_out <= 1'b0;
					repeat (half_in) @(posedge sys_clk_in);
				end
				busy_out <= 1'b0;
			end
		end
	end
endmodule : cmec_pulse_src

/* tb/tb.sv */
// self-checking bench of the compare-match event counter
// assumes the wishbone answer comes within 100 cycles; seed fixed for repeatable runs
module tb
	import cmec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam logic [31:0] C_GO = 32'h1 << CMEC_CTRL_START;
	localparam logic [31:0] C_STOP = 32'h1 << CMEC_CTRL_STOP;
	localparam logic [31:0] C_RST = 32'h1 << CMEC_CTRL_CNT_RST;
	localparam logic [31:0] C_STAT = 32'h1 << CMEC_CTRL_STAT_RST;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic go = 1'b0;
	logic busy, src, wb_ack, ev_m, ev_o, ev_e;
	logic [7:0] npl = 8'h00;
	logic [7:0] half = 8'h00;
	logic [31:0] wb_dat, rd;
	cmec_wb_req_t wb = '0;
	int err_total = 0;
	int checked = 0;
	int n_m = 0;
	int n_o = 0;
	int n_e = 0;
	int seed = 32'hff00;
	int v[3];
	int n, r, w, j, prev;

	cmec_counter dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .wb_req_in(wb),
		.wb_dat_out(wb_dat), .wb_ack_out(wb_ack), .cnt_src_in(src),
		.ev_match_out(ev_m), .ev_overrun_out(ev_o), .ev_error_out(ev_e));
	cmec_pulse_src src_mdl (.sys_clk_in(sys_clk_in), .go_in(go), .npulse_in(npl),
		.half_in(half), .src_out(src), .busy_out(busy));

	// 40 MHz clock
	initial begin
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	// event pulses are one cycle wide, so counting them per edge is exact
	always @(posedge sys_clk_in) begin
		n_m += (ev_m === 1'b1);
		n_o += (ev_o === 1'b1);
		n_e += (ev_e === 1'b1);
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic give_verdict;
		$display("counts: %0d checked, %0d mismatches", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// expected status word, built from the field positions
	function automatic logic [31:0] stat_word(input logic run, input logic mt,
		input logic ov, input logic er);
		stat_word = (32'(run) << CMEC_STAT_RUN) | (32'(mt) << CMEC_STAT_MATCH)
			| (32'(ov) << CMEC_STAT_OVR) | (32'(er) << CMEC_STAT_ERR);
	endfunction : stat_word

	// expected compare value after match jj of the three-entry list
	function automatic logic [31:0] next_cmp(input int jj, input int wrap);
		if (jj < 2) begin
			next_cmp = 32'(v[jj + 1]);
		end else if (wrap != 0) begin
			next_cmp = 32'(v[0]);
		end else begin
			next_cmp = 32'(v[2]);
		end
	endfunction : next_cmp

	// classic cycle: hold until ack is sampled, then one idle cycle
	task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		wb <= '{1'b1, 1'b1, we, a, 4'hf, d};
		k = 0;
		do begin
			@(posedge sys_clk_in);
			k++;
		end while (wb_ack !== 1'b1 && k < 100);
		rd = wb_dat;
		wb <= '0;
		@(posedge sys_clk_in);
		if (k >= 100) begin
			err_total++;
			$display("mismatch at %0t: bus timeout", $time);
			give_verdict();
		end
	endtask : wb_io

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_io(1'b1, a, d);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb_io(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask : rchk

	// burst of n pulses, each level held h cycles, then pipeline settle
	task automatic pulses(input int p, input int h);
		int k;
		npl <= 8'(p);
		half <= 8'(h);
		go <= 1'b1;
		@(posedge sys_clk_in);
		go <= 1'b0;
		@(posedge sys_clk_in);
		k = 0;
		while (busy === 1'b1 && k < 30000) begin
			@(posedge sys_clk_in);
			k++;
		end
		if (k >= 30000) begin
			err_total++;
			$display("mismatch at %0t: source timeout", $time);
			give_verdict();
		end
		repeat (8) @(posedge sys_clk_in);
	endtask : pulses

	task automatic load_list(input int a, input int b, input int c, input logic [31:0] cfg);
		wr(CMEC_OFS_CTRL, C_RST);
		wr(CMEC_OFS_LIST_PTR, 32'h0);
		wr(CMEC_OFS_LIST_DATA, 32'(a));
		wr(CMEC_OFS_LIST_DATA, 32'(b));
		wr(CMEC_OFS_LIST_DATA, 32'(c));
		wr(CMEC_OFS_LIST_LAST, 32'h2);
		wr(CMEC_OFS_CONFIG, cfg);
		wr(CMEC_OFS_CTRL, C_GO);
	endtask : load_list

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (5) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		@(posedge sys_clk_in);
		rchk(CMEC_OFS_STATUS, 32'h0, "status after reset");
		rchk(CMEC_OFS_COUNT, 32'h0, "count after reset");
		r = $random(seed);
		wr(CMEC_OFS_CONFIG, 32'(r));
		rchk(CMEC_OFS_CONFIG, 32'(r & 7), "config");
		wr(CMEC_OFS_COMPARE, 32'(r));
		rchk(CMEC_OFS_COMPARE, 32'(r), "compare value");
		rchk(8'h20, 32'h0, "unmapped");
		wr(CMEC_OFS_CTRL, C_RST);
		$display("test registers done");
		n = 3 + ($random(seed) & 7);
		pulses(2, 3);
		wr(CMEC_OFS_CTRL, C_GO);
		rchk(CMEC_OFS_STATUS, stat_word(1'b1, 1'b0, 1'b0, 1'b0), "running");
		pulses(n, 3);
		rchk(CMEC_OFS_COUNT, 32'(n), "count while running");
		wr(CMEC_OFS_CTRL, C_STOP);
		pulses(3, 3);
		rchk(CMEC_OFS_COUNT, 32'(n), "count after stop");
		rchk(CMEC_OFS_STATUS, 32'h0, "stopped");
		wr(CMEC_OFS_CTRL, C_GO | C_STOP);
		rchk(CMEC_OFS_STATUS, stat_word(1'b0, 1'b0, 1'b0, 1'b0), "stop wins");
		$display("test counting done");
		for (w = 0; w < 2; w++) begin
			v[0] = 2 + ($random(seed) & 3);
			v[1] = v[0] + 1 + ($random(seed) & 3);
			v[2] = v[1] + 1 + ($random(seed) & 3);
			load_list(v[0], v[1], v[2], 32'h2 | 32'(w << CMEC_CFG_WRAP_EN));
			rchk(CMEC_OFS_COMPARE, 32'(v[0]), "first compare");
			rchk(CMEC_OFS_LIST_LAST, 32'h2, "last index");
			wr(CMEC_OFS_LIST_PTR, 32'h1);
			rchk(CMEC_OFS_LIST_DATA, 32'(v[1]), "list entry");
			n_m = 0;
			prev = 0;
			for (j = 0; j < 3; j++) begin
				pulses(v[j] - prev, 3);
				prev = v[j];
				rchk(CMEC_OFS_COUNT, 32'(v[j]), "match count");
				chk(n_m, j + 1, "match events");
				rchk(CMEC_OFS_COMPARE, next_cmp(j, w), "next");
				rchk(CMEC_OFS_STATUS, stat_word(1'b1, 1'b1, 1'b0, 1'b0), "match flag");
				wr(CMEC_OFS_CTRL, C_STAT);
				rchk(CMEC_OFS_STATUS, stat_word(1'b1, 1'b0, 1'b0, 1'b0), "cleared");
			end
		end
		$display("test compare list done");
		load_list(1, 2, 3, 32'h6);
		n_o = 0;
		n_e = 0;
		pulses(1, 3);
		rchk(CMEC_OFS_STATUS, stat_word(1'b1, 1'b1, 1'b0, 1'b0), "first match");
		pulses(1, 3);
		rchk(CMEC_OFS_STATUS, stat_word(1'b1, 1'b1, 1'b1, 1'b0), "overrun");
		chk(n_o, 1, "overrun event");
		pulses(1, 3);
		rchk(CMEC_OFS_STATUS, stat_word(1'b0, 1'b1, 1'b1, 1'b1), "op error");
		chk(n_e, 1, "error event");
		pulses(2, 3);
		rchk(CMEC_OFS_COUNT, 32'h3, "halted count");
		wr(CMEC_OFS_CTRL, C_STAT);
		rchk(CMEC_OFS_STATUS, stat_word(1'b0, 1'b0, 1'b0, 1'b1), "status reset");
		wr(CMEC_OFS_CTRL, C_RST);
		rchk(CMEC_OFS_STATUS, 32'h0, "status after counter reset");
		rchk(CMEC_OFS_CONFIG, 32'h0, "config after counter reset");
		$display("test overrun and error done");
		wr(CMEC_OFS_CONFIG, 32'h1);
		wr(CMEC_OFS_CTRL, C_GO);
		pulses(1, 10);
		rchk(CMEC_OFS_COUNT, 32'h0, "short pulse filtered");
		pulses(1, 50);
		rchk(CMEC_OFS_COUNT, 32'h1, "long pulse counted");
		$display("test filter done");
		// power-on reset in mid-run must give the same state as at start
		resetn_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		@(posedge sys_clk_in);
		rchk(CMEC_OFS_COUNT, 32'h0, "count after mid-run reset");
		rchk(CMEC_OFS_CONFIG, 32'h0, "config after mid-run reset");
		$display("test reset done");
		give_verdict();
	end
endmodule : tb
